// File: extended_ram_decoder_defs.svh
`ifndef EXTENDED_RAM_DECODER_DEFS_SVH
`define EXTENDED_RAM_DECODER_DEFS_SVH
// Overview of operation
// - lower 128 bytes reachable by direct and indirect addressing
// - upper 128 bytes of internal RAM reachable by indirect addressing only
// - control register space shares upper range, reachable by direct addressing only
// - direct access above 7fh selects control register space
// - indirect access above 7fh selects upper RAM byte
// - stack reaches all 256 internal RAM bytes, never extended RAM
// - stretch bit lengthens external strobes from 7 to 31 clocks
// - external select cleared at reset routes in-window accesses on chip
// - size select cleared gives 256 bytes, set gives 512 bytes
// - extended RAM reached by external moves; in-window addresses hit on chip
// - above window accesses go to external bus, data pointer moves only
// - external select set sends all extended accesses off chip, 64 KB
// - register-indirect move drives 8-bit address muxed on low port
// - pointer move drives high byte on high port, low byte muxed
// - read strobe low for loads, write strobe low for stores
// - on-chip extended RAM access leaves ports and strobes untouched
// - two 16-bit data pointers chosen by one select bit
// - pointer control bit 2 reads zero so increment toggles select only
// - external select at bit 1, size select at bit 2 of aux control
// - pointer select at bit 0 of pointer control register
`define ADDR_DATA_LO 32'h0000_0000
`define ADDR_DATA_HI 32'h0000_0004
`define ADDR_AUX_CTRL 32'h0000_0008
`define ADDR_PTR_CTRL 32'h0000_000c
`define ADDR_PTR0 32'h0000_0010
`define ADDR_PTR1 32'h0000_0014
`define ADDR_XMOVE 32'h0000_0018
`define ADDR_XSTATUS 32'h0000_001c
`define ADDR_RAM_ACC 32'h0000_0020
`define ADDR_SP 32'h0000_0024
`define ADDR_PUSH 32'h0000_0028
`define ADDR_SPACE_RD 32'h0000_002c
`define AUX_STRETCH_BIT 0
`define AUX_EXT_BIT 1
`define AUX_SIZE_BIT 2
`define PTR_SEL_BIT 0
`define PTR_ZERO_BIT 2
`define PTR_FLAG_BIT 3
`define MV_DATA_POINTER_BIT 0
`define MV_WRITE_BIT 1
`define MV_RI_LSB 8
`define RA_INDIRECT_BIT 8
`define RA_WRITE_BIT 9
`define RA_DATA_LSB 16
`define STROBE_SHORT 6
`define STROBE_LONG 30
`define WIN_SMALL_END 16'h00ff
`define WIN_LARGE_END 16'h01ff
`define LOWER_END 8'h7f
`define SP_RESET 8'h07
`define RDATA_BAD 32'h0000_0000
`endif

// File: extended_ram_decoder_pkg.sv
package extended_ram_decoder_pkg;
  typedef enum logic [1:0] {
    SPACE_LOWER,
    SPACE_UPPER,
    SPACE_CTRL
  } space_t;
  typedef enum logic [1:0] {
    TGT_ONCHIP,
    TGT_EXT_RI,
    TGT_EXT_PTR,
    TGT_REFUSE
  } xtarget_t;
  typedef struct packed {
    logic use_ptr;
    logic write;
    logic [7:0] ri;
  } xmove_t;
  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic drive_hi;
  } ext_addr_t;
endpackage : extended_ram_decoder_pkg

// File: ext_strobe_timer.sv
`timescale 1ns/1ps
`include "extended_ram_decoder_defs.svh"
// counts the active strobe width; short or stretched
module ext_strobe_timer #(
  parameter int CNT_W = 5
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic stretch_i,
  output logic busy_o,
  output logic done_o
);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        cnt_q <= stretch_i ? CNT_W'(`STROBE_LONG - 1) : CNT_W'(`STROBE_SHORT - 1);
      end else if (busy_o) begin
        if (cnt_q == '0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule : ext_strobe_timer

// File: data_memory_extended_ram_decoder.sv
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "extended_ram_decoder_defs.svh"
module data_memory_extended_ram_decoder
  import extended_ram_decoder_pkg::*;
#(
  parameter int EXTENDED_RAM_BYTES = 512,
  parameter int IRAM_BYTES = 256
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] low_address_data_port_i,
  output logic [7:0] low_address_data_port_o,
  output logic low_address_data_port_oe_o,
  output logic [7:0] high_address_port_o,
  output logic high_address_port_oe_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o
);
  logic [7:0] iram_q [IRAM_BYTES];
  logic [7:0] extended_ram_q [EXTENDED_RAM_BYTES];
  logic [7:0] ctrl_q [128];
  logic [7:0] sp_q;
  logic [15:0] data_pointer_q [2];
  logic ext_sel_q, size_sel_q, stretch_q, ptr_sel_q, flag_q;
  logic [7:0] data_lo_q;
  logic [7:0] xfer_data_q;
  logic xfer_busy_q, xfer_write_q, xfer_err_q;
  logic start_q;
  logic tmr_busy, tmr_done;

  logic setup, acc, wr_acc, rd_acc;
  xmove_t mv;
  logic [15:0] x_addr, win_end;
  xtarget_t tgt;
  ext_addr_t ea;
  space_t sp_space;
  logic [7:0] ra_addr;

  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign mv = xmove_t'({pwdata[`MV_DATA_POINTER_BIT], pwdata[`MV_WRITE_BIT], pwdata[`MV_RI_LSB +: 8]});
  assign ra_addr = pwdata[7:0];

  // external move decode
  always_comb begin
    win_end = size_sel_q ? `WIN_LARGE_END : `WIN_SMALL_END;
    x_addr = mv.use_ptr ? data_pointer_q[ptr_sel_q] : {8'h00, mv.ri};
    ea = '{addr_hi: x_addr[15:8], addr_lo: x_addr[7:0], drive_hi: mv.use_ptr};
    if (!ext_sel_q && x_addr <= win_end) begin
      tgt = TGT_ONCHIP;
    end else if (mv.use_ptr) begin
      tgt = TGT_EXT_PTR;
    end else if (ext_sel_q) begin
      tgt = TGT_EXT_RI;
    end else begin
      tgt = TGT_REFUSE;
    end
  end

  // addressing-mode space select above the lower range
  function automatic space_t space_of(input logic [7:0] a, input logic indirect);
    if (a <= `LOWER_END) begin
      return SPACE_LOWER;
    end else if (indirect) begin
      return SPACE_UPPER;
    end else begin
      return SPACE_CTRL;
    end
  endfunction : space_of

  assign sp_space = space_of(sp_q + 8'h01, 1'b1);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sel_q <= 1'b0;
      size_sel_q <= 1'b0;
      stretch_q <= 1'b0;
      ptr_sel_q <= 1'b0;
      flag_q <= 1'b0;
      data_lo_q <= 8'h00;
    end else if (wr_acc) begin
      case (paddr)
        `ADDR_AUX_CTRL: begin
          stretch_q <= pwdata[`AUX_STRETCH_BIT];
          ext_sel_q <= pwdata[`AUX_EXT_BIT];
          size_sel_q <= pwdata[`AUX_SIZE_BIT];
        end
        `ADDR_PTR_CTRL: begin
          ptr_sel_q <= pwdata[`PTR_SEL_BIT];
          flag_q <= pwdata[`PTR_FLAG_BIT];
        end
        `ADDR_DATA_LO: data_lo_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_pointer_q[0] <= 16'h0000;
      data_pointer_q[1] <= 16'h0000;
    end else if (wr_acc && paddr == `ADDR_PTR0) begin
      data_pointer_q[0] <= pwdata[15:0];
    end else if (wr_acc && paddr == `ADDR_PTR1) begin
      data_pointer_q[1] <= pwdata[15:0];
    end else if (wr_acc && paddr == `ADDR_DATA_HI) begin
      data_pointer_q[ptr_sel_q] <= {pwdata[7:0], data_pointer_q[ptr_sel_q][7:0]};
    end
  end

  // stack pointer and push
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_q <= `SP_RESET;
    end else if (wr_acc && paddr == `ADDR_SP) begin
      sp_q <= pwdata[7:0];
    end else if (wr_acc && paddr == `ADDR_PUSH) begin
      sp_q <= sp_q + 8'h01;
    end
  end

  // internal RAM and control space; stack never lands in extended RAM
  always_ff @(posedge sys_clk_i) begin
    if (wr_acc && paddr == `ADDR_PUSH) begin
      iram_q[sp_q + 8'h01] <= pwdata[7:0];
    end else if (wr_acc && paddr == `ADDR_RAM_ACC && pwdata[`RA_WRITE_BIT]) begin
      if (space_of(ra_addr, pwdata[`RA_INDIRECT_BIT]) == SPACE_CTRL) begin
        ctrl_q[ra_addr[6:0]] <= pwdata[`RA_DATA_LSB +: 8];
      end else begin
        iram_q[ra_addr] <= pwdata[`RA_DATA_LSB +: 8];
      end
    end
  end

  // on-chip extended RAM; ports are left alone here
  always_ff @(posedge sys_clk_i) begin
    if (wr_acc && paddr == `ADDR_XMOVE && tgt == TGT_ONCHIP && mv.write) begin
      extended_ram_q[x_addr[8:0]] <= data_lo_q;
    end
  end

  // external bus cycle: address phase then strobe of 7 or 31 clocks
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xfer_busy_q <= 1'b0;
      xfer_write_q <= 1'b0;
      xfer_err_q <= 1'b0;
      xfer_data_q <= 8'h00;
      start_q <= 1'b0;
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      low_address_data_port_o <= 8'h00;
      low_address_data_port_oe_o <= 1'b0;
      high_address_port_o <= 8'h00;
      high_address_port_oe_o <= 1'b0;
    end else begin
      start_q <= 1'b0;
      ale_o <= 1'b0;
      if (wr_acc && paddr == `ADDR_XMOVE && !xfer_busy_q) begin
        xfer_err_q <= (tgt == TGT_REFUSE);
        if (tgt == TGT_ONCHIP) begin
          xfer_data_q <= extended_ram_q[x_addr[8:0]];
        end else if (tgt != TGT_REFUSE) begin
          xfer_busy_q <= 1'b1;
          xfer_write_q <= mv.write;
          ale_o <= 1'b1;
          start_q <= 1'b1;
          low_address_data_port_o <= ea.addr_lo;
          low_address_data_port_oe_o <= 1'b1;
          if (ea.drive_hi) begin
            high_address_port_o <= ea.addr_hi;
            high_address_port_oe_o <= 1'b1;
          end
        end
      end else if (start_q) begin
        if (xfer_write_q) begin
          low_address_data_port_o <= data_lo_q;
          wr_n_o <= 1'b0;
        end else begin
          low_address_data_port_oe_o <= 1'b0;
          rd_n_o <= 1'b0;
        end
      end else if (tmr_done) begin
        if (!xfer_write_q) begin
          xfer_data_q <= low_address_data_port_i;
        end
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        low_address_data_port_oe_o <= 1'b0;
        high_address_port_oe_o <= 1'b0;
        xfer_busy_q <= 1'b0;
      end
    end
  end

  ext_strobe_timer #(
    .CNT_W(5)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start_q),
    .stretch_i(stretch_q),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  // read data
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata <= `RDATA_BAD;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      prdata <= `RDATA_BAD;
      case (paddr)
        `ADDR_DATA_LO: prdata <= {24'h0, xfer_data_q};
        `ADDR_AUX_CTRL: prdata <= {29'h0, size_sel_q, ext_sel_q, stretch_q};
        `ADDR_PTR_CTRL: prdata <= {28'h0, flag_q, 1'b0, 1'b0, ptr_sel_q};
        `ADDR_PTR0: prdata <= {16'h0, data_pointer_q[0]};
        `ADDR_PTR1: prdata <= {16'h0, data_pointer_q[1]};
        `ADDR_XSTATUS: prdata <= {29'h0, tmr_busy, xfer_err_q, xfer_busy_q};
        `ADDR_SP: prdata <= {24'h0, sp_q};
        `ADDR_SPACE_RD: prdata <= {30'h0, sp_space};
        `ADDR_RAM_ACC: begin
          if (space_of(pwdata[7:0], pwdata[`RA_INDIRECT_BIT]) == SPACE_CTRL) begin
            prdata <= {24'h0, ctrl_q[pwdata[6:0]]};
          end else begin
            prdata <= {24'h0, iram_q[pwdata[7:0]]};
          end
        end
        `ADDR_DATA_HI, `ADDR_XMOVE, `ADDR_PUSH: ;
        default: pslverr <= 1'b1;
      endcase
    end
  end
endmodule : data_memory_extended_ram_decoder

// File: extended_ram_decoder_props.sv
`timescale 1ns/1ps
module extended_ram_decoder_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic low_address_data_port_oe_o,
  input wire logic ale_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_excl; !(!rd_n_o && !wr_n_o); endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_ale; ale_o |=> !ale_o; endproperty
  a_ale: assert property (p_ale) else $error("latch pulse too long");
  property p_ale_oe; ale_o |-> low_address_data_port_oe_o; endproperty
  a_ale_oe: assert property (p_ale_oe) else $error("address not driven");
  property p_strobe; ale_o |=> (!rd_n_o || !wr_n_o); endproperty
  a_strobe: assert property (p_strobe) else $error("no strobe after address");
  property p_wr_min; $fell(wr_n_o) |-> !wr_n_o [*6]; endproperty
  a_wr_min: assert property (p_wr_min) else $error("write strobe short");
  property p_rd_max; $fell(rd_n_o) |-> ##[6:32] rd_n_o; endproperty
  a_rd_max: assert property (p_rd_max) else $error("read strobe stuck");
  property p_wr_oe; !wr_n_o |-> low_address_data_port_oe_o; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write data not driven");
  property p_rd_oe; !rd_n_o |-> !low_address_data_port_oe_o; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("port driven in read");
  c_rd: cover property ($fell(rd_n_o));
  c_wr: cover property ($fell(wr_n_o));
  c_long: cover property (!wr_n_o [*8]);
endmodule : extended_ram_decoder_props
bind data_memory_extended_ram_decoder extended_ram_decoder_props u_props (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pready(pready),
  .low_address_data_port_oe_o(low_address_data_port_oe_o), .ale_o(ale_o),
  .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));

// File: ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic hi_oe_i,
  input wire logic [7:0] lo_i,
  input wire logic [7:0] hi_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:65535];
  logic [15:0] a_q = 16'h0000;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i);
  // undriven high port means page zero, no paging latch here
  always @(posedge clk_i) begin
    if (ale_i) a_q <= {hi_oe_i ? hi_i : 8'h00, lo_i};
    if (!wr_n_i) mem[a_q] <= lo_i;
  end
  // released bus shows the inverse so stale data never matches
  assign data_o = rd_n_i ? ~mem[a_q] : mem[a_q];
endmodule : ext_mem_model

// File: data_memory_extended_ram_decoder_tb.sv
`timescale 1ns/1ps
module data_memory_extended_ram_decoder_tb;
  logic sys_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, ev, ale, rd_n, wr_n, oe, hoe;
  logic [31:0] paddr, pwdata, prdata, rv;
  logic [7:0] din, dout, hout;
  int errors, n_checks, ales, hcnt, w, lw;
  data_memory_extended_ram_decoder dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_address_data_port_i(din),
    .low_address_data_port_o(dout), .low_address_data_port_oe_o(oe),
    .high_address_port_o(hout), .high_address_port_oe_o(hoe), .ale_o(ale),
    .rd_n_o(rd_n), .wr_n_o(wr_n));
  ext_mem_model mem (.clk_i(sys_clk_i), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .hi_oe_i(hoe), .lo_i(dout), .hi_i(hout), .data_o(din));
  initial begin
    sys_clk_i = 0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    ales <= ales + int'(ale);
    hcnt <= hcnt + int'(hoe);
    w <= (rd_n && wr_n) ? 0 : w + 1;
    if (rd_n && wr_n && w != 0) lw <= w;
  end
  function automatic logic goes_out(input logic ext, sz, input logic [15:0] a);
    return ext || a > (sz ? 16'h01ff : 16'h00ff);
  endfunction : goes_out
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [31:0] a, d);
    int k = 0;
    @(posedge sys_clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) errors++;
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : bus
  task automatic mv(input logic [31:0] c);
    int k = 0;
    bus(1, 32'h18, c);
    do begin
      bus(0, 32'h1c, 32'h0);
      k++;
    end while (rv[0] !== 1'b0 && k < 60);
    if (k == 60) errors++;
  endtask : mv
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    #500000;
    errors++;
    conclude();
  end
  initial begin
    logic [31:0] d, a, cfg;
    logic [15:0] x;
    logic p, e;
    int n0, h0;
    {psel, penable, pwrite, paddr, pwdata, rst_n_i} = '0;
    void'($urandom(32'h4cb0));
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1;
    bus(0, 32'h08, 32'h0);
    chk(rv & 32'h7, 32'h0);
    bus(0, 32'h24, 32'h0);
    chk(rv[7:0], 8'h07);
    bus(0, 32'h40, 32'h0);
    chk(ev, 1'b1);
    bus(1, 32'h0c, 32'hf);
    bus(0, 32'h0c, 32'h0);
    chk(rv & 32'hd, 32'h9);
    bus(1, 32'h0c, (rv & 32'hd) + 1);
    bus(0, 32'h0c, 32'h0);
    chk(rv & 32'hd, 32'h8);
    for (int i = 0; i < 2; i++) begin
      d = $urandom;
      bus(1, 32'h10 + 4 * i, d);
      bus(0, 32'h10 + 4 * i, 32'h0);
      chk(rv[15:0], d[15:0]);
      a = {24'h0, i[0], 7'($urandom)};
      bus(1, 32'h20, {8'h0, d[7:0], 7'h01, i[0], a[7:0]});
      bus(0, 32'h20, {16'h0, 8'h01, a[7:0]});
      chk(rv[7:0], d[7:0]);
    end
    // same offset above the lower range: direct hits control space, indirect hits upper ram
    bus(1, 32'h20, 32'h005a_02a0);
    bus(1, 32'h20, 32'h00a5_03a0);
    bus(0, 32'h20, 32'h0000_00a0);
    chk(rv[7:0], 8'h5a);
    bus(0, 32'h20, 32'h0000_01a0);
    chk(rv[7:0], 8'ha5);
    $display("registers and internal ram done");
    bus(1, 32'h24, 32'h7e);
    bus(0, 32'h2c, 32'h0);
    chk(rv[0], 1'b0);
    bus(1, 32'h24, 32'h7f);
    bus(0, 32'h2c, 32'h0);
    chk(rv[0], 1'b1);
    d = $urandom;
    bus(1, 32'h28, d);
    bus(0, 32'h20, 32'h180);
    chk(rv[7:0], d[7:0]);
    $display("stack done");
    for (int i = 0; i < 10; i++) begin
      cfg = ($urandom % 8) | (i > 7 ? 32'h3 : 32'h0);
      p = i[0];
      a = (i == 9) ? 32'hffff : $urandom % 32'h400;
      x = p ? a[15:0] : {8'h00, a[7:0]};
      e = goes_out(cfg[1], cfg[2], x);
      bus(1, 32'h08, cfg);
      bus(1, 32'h0c, 32'h0);
      bus(1, 32'h10, a);
      d = $urandom;
      bus(1, 32'h00, d);
      n0 = ales;
      h0 = hcnt;
      mv({16'h0, a[7:0], 7'h01, p});
      chk(ales - n0, {31'h0, e});
      if (e) begin
        chk(mem.mem[x], d[7:0]);
        chk(hcnt > h0, p);
        chk(lw / 8, cfg[0] ? 3 : 0);
      end
      bus(1, 32'h00, ~d);
      mv({16'h0, a[7:0], 7'h00, p});
      bus(0, 32'h00, 32'h0);
      chk(rv[7:0], d[7:0]);
    end
    $display("extended memory done");
    conclude();
  end
endmodule : data_memory_extended_ram_decoder_tb
